/* File: core/pci_pkg.sv */
// shared constants and types for the parameter command interpreter
`default_nettype none
package pci_pkg;
    // frame and table geometry
    localparam int unsigned FRAME_BYTES   = 9;
    localparam int unsigned NUM_PARAMS    = 256;
    localparam logic [7:0]  ADDR_DEFAULT  = 8'h01;
    localparam logic [7:0]  MOTOR_ONLY    = 8'h00;
    localparam logic [31:0] ACCU_RESET    = 32'h0000_0000;
    localparam logic [31:0] VALUE_DONT    = 32'h0000_0000;

    // instruction codes
    localparam logic [7:0] OP_SET_AXIS      = 8'h05;
    localparam logic [7:0] OP_GET_AXIS      = 8'h06;
    localparam logic [7:0] OP_STORE_AXIS    = 8'h07;
    localparam logic [7:0] OP_RESTORE_AXIS  = 8'h08;
    localparam logic [7:0] OP_SET_GLOBAL    = 8'h09;
    localparam logic [7:0] OP_GET_GLOBAL    = 8'h0a;
    localparam logic [7:0] OP_STORE_GLOBAL  = 8'h0b;
    localparam logic [7:0] OP_RESTORE_GLOBAL = 8'h0c;

    // bank codes
    localparam logic [7:0] BANK_MODULE = 8'h00;
    localparam logic [7:0] BANK_USER   = 8'h02;
    localparam logic [7:0] BANK_IRQ    = 8'h03;

    // reply status codes
    localparam logic [7:0] STAT_OK       = 8'h64;
    localparam logic [7:0] STAT_BAD_SUM  = 8'h01;
    localparam logic [7:0] STAT_BAD_CMD  = 8'h02;
    localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
    localparam logic [7:0] STAT_BAD_BANK = 8'h04;

    // received frame, fields in wire order
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  opcode;
        logic [7:0]  ptype;
        logic [7:0]  bank;
        logic [31:0] value;
    } pci_frame_s;

    typedef struct packed {
        logic [7:0]  module_addr;
        logic [7:0]  status;
        logic [7:0]  opcode;
        logic [31:0] value;
    } pci_reply_s;

    typedef enum logic [1:0] {
        PCI_LOAD  = 2'b00,
        PCI_IDLE  = 2'b01,
        PCI_REPLY = 2'b11
    } pci_state_e;
endpackage
`default_nettype wire

/* File: core/pci_frame_rx.sv */
// byte collector that assembles command frames and checks their sum
`default_nettype none
module pci_frame_rx (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // byte stream from host
    input  wire logic          byte_valid_in,
    input  wire logic [7:0]    byte_in,
    output logic               byte_ready_out,
    // assembled frame
    output logic               frame_valid_out,
    output pci_pkg::pci_frame_s frame_out,
    output logic               sum_ok_out,
    input  wire logic          frame_take_in
);
    logic [3:0]  cnt_q;
    logic [63:0] shift_q;
    logic [7:0]  sum_q;
    logic        full_q;
    logic        byte_fire;
    logic        last_byte;

    // one frame held at a time; host is stalled until it is taken
    assign byte_ready_out  = !full_q;
    assign byte_fire       = byte_valid_in && !full_q;
    assign last_byte       = (cnt_q == 4'(pci_pkg::FRAME_BYTES - 1));
    assign frame_valid_out = full_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q   <= 4'h0;
            shift_q <= 64'h0;
            sum_q   <= 8'h00;
        end else if (byte_fire) begin
            if (last_byte) begin
                cnt_q <= 4'h0;
                sum_q <= 8'h00;
            end else begin
                cnt_q   <= cnt_q + 4'h1;
                shift_q <= {shift_q[55:0], byte_in};
                sum_q   <= sum_q + byte_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            full_q     <= 1'b0;
            frame_out  <= '0;
            sum_ok_out <= 1'b0;
        end else if (byte_fire && last_byte) begin
            full_q     <= 1'b1;
            frame_out  <= shift_q;
            sum_ok_out <= (sum_q == byte_in);
        end else if (frame_take_in) begin
            full_q <= 1'b0;
        end
    end
endmodule // pci_frame_rx
`default_nettype wire

/* File: core/pci_core.sv */
// parameter command interpreter: frame decode, parameter tables, replies
// Behaviour
// - get axis parameter (6) reads the parameter chosen by type into accumulator
// - get axis/global reply carries status 100 and the value read
// - store axis parameter (7) copies working value to nonvolatile, replies 100
// - restore axis parameter (8) reloads working value from nonvolatile, replies 100
// - after power-up every axis working value loads from its nonvolatile copy
// - set global parameter (9) writes value into type/bank entry, replies 100
// - bank 0 module settings, bank 2 user variables, bank 3 interrupt setup
// - writing a bank 0 setting also commits it to nonvolatile storage
// - get global parameter (10) copies selected entry into accumulator
// - store global saves bank 2 variable; power-on restore automatic or on request
// - frame order: address, code, type, bank, value MSB first, checksum
// - in direct host mode reads leave the accumulator unchanged
// - store global is code 11 and replies status 100
// - restore global (12) reloads user variable from nonvolatile, replies 100
`default_nettype none
module pci_core #(
    parameter int unsigned NUM_PARAMS  = pci_pkg::NUM_PARAMS,
    parameter logic [7:0]  MODULE_ADDR = pci_pkg::ADDR_DEFAULT
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // mode straps from pins
    input  wire logic          standalone_in,
    input  wire logic          auto_restore_in,
    // command byte stream
    input  wire logic          byte_valid_in,
    input  wire logic [7:0]    byte_in,
    output logic               byte_ready_out,
    // reply
    output logic               reply_valid_out,
    input  wire logic          reply_ready_in,
    output pci_pkg::pci_reply_s reply_out,
    // status
    output logic [31:0]        accu_out,
    output logic               busy_out
);
    localparam int unsigned IDX_W = $clog2(NUM_PARAMS);

    logic                rst_meta_q;
    logic                rst_n;
    logic [1:0]          stand_sync_q;
    logic [1:0]          auto_sync_q;
    logic                standalone_q;
    logic                auto_restore_q;
    pci_pkg::pci_state_e state_q;
    logic [IDX_W-1:0]    ld_idx_q;
    logic [IDX_W-1:0]    cmd_idx_q;
    logic [31:0]         accu_q;
    pci_pkg::pci_reply_s reply_q;

    logic [31:0] axis_work_q [NUM_PARAMS];
    logic [31:0] axis_nv_q   [NUM_PARAMS];
    logic [31:0] g0_work_q   [NUM_PARAMS];
    logic [31:0] g0_nv_q     [NUM_PARAMS];
    logic [31:0] g2_work_q   [NUM_PARAMS];
    logic [31:0] g2_nv_q     [NUM_PARAMS];
    logic [31:0] g3_work_q   [NUM_PARAMS];

    pci_pkg::pci_frame_s frm;
    logic                frm_valid;
    logic                sum_ok;
    logic                go;
    logic                addr_hit;
    logic                exec;
    logic [IDX_W-1:0]    idx;
    logic                type_ok;
    logic [7:0]          cmd_status;
    logic [31:0]         cmd_value;
    logic [31:0]         axis_rd;
    logic [31:0]         glob_rd;
    logic                ax_set;
    logic                ax_store;
    logic                ax_restore;
    logic                g_set;
    logic                g_store;
    logic                g_restore;
    logic                accu_ld;
    logic                load_last;

    // reset release through two flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // straps run from the raw reset so they are settled before the load phase starts
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stand_sync_q <= 2'b00;
            auto_sync_q  <= 2'b00;
        end else begin
            stand_sync_q <= {stand_sync_q[0], standalone_in};
            auto_sync_q  <= {auto_sync_q[0], auto_restore_in};
        end
    end
    assign standalone_q   = stand_sync_q[1];
    assign auto_restore_q = auto_sync_q[1];

    pci_frame_rx u_rx (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n),
        .byte_valid_in   (byte_valid_in),
        .byte_in         (byte_in),
        .byte_ready_out  (byte_ready_out),
        .frame_valid_out (frm_valid),
        .frame_out       (frm),
        .sum_ok_out      (sum_ok),
        .frame_take_in   (go)
    );

    assign go        = (state_q == pci_pkg::PCI_IDLE) && frm_valid;
    assign addr_hit  = (frm.addr == MODULE_ADDR);
    assign exec      = go && addr_hit && sum_ok;
    assign idx       = frm.ptype[IDX_W-1:0];
    assign type_ok   = (32'(frm.ptype) < NUM_PARAMS);
    assign axis_rd   = axis_work_q[idx];
    assign load_last = (32'(ld_idx_q) == NUM_PARAMS - 1);

    // bank decode for global reads
    always_comb begin
        unique case (frm.bank)
            pci_pkg::BANK_MODULE: glob_rd = g0_work_q[idx];
            pci_pkg::BANK_USER:   glob_rd = g2_work_q[idx];
            default:              glob_rd = g3_work_q[idx];
        endcase
    end

    always_comb begin
        logic bank_any;
        logic bank_nv;
        logic axis_ok;
        bank_any   = (frm.bank == pci_pkg::BANK_MODULE) || (frm.bank == pci_pkg::BANK_USER)
                     || (frm.bank == pci_pkg::BANK_IRQ);
        bank_nv    = (frm.bank == pci_pkg::BANK_MODULE) || (frm.bank == pci_pkg::BANK_USER);
        axis_ok    = (frm.bank == pci_pkg::MOTOR_ONLY);
        cmd_status = pci_pkg::STAT_OK;
        cmd_value  = pci_pkg::VALUE_DONT;
        ax_set     = 1'b0;
        ax_store   = 1'b0;
        ax_restore = 1'b0;
        g_set      = 1'b0;
        g_store    = 1'b0;
        g_restore  = 1'b0;
        accu_ld    = 1'b0;
        unique case (frm.opcode)
            pci_pkg::OP_SET_AXIS:       ax_set     = axis_ok;
            pci_pkg::OP_GET_AXIS: begin
                accu_ld   = axis_ok;
                cmd_value = axis_rd;
            end
            pci_pkg::OP_STORE_AXIS:     ax_store   = axis_ok;
            pci_pkg::OP_RESTORE_AXIS:   ax_restore = axis_ok;
            pci_pkg::OP_SET_GLOBAL:     g_set      = bank_any;
            pci_pkg::OP_GET_GLOBAL: begin
                accu_ld   = bank_any;
                cmd_value = glob_rd;
            end
            pci_pkg::OP_STORE_GLOBAL:   g_store    = bank_nv;
            pci_pkg::OP_RESTORE_GLOBAL: g_restore  = bank_nv;
            default:                    cmd_status = pci_pkg::STAT_BAD_CMD;
        endcase
        if (cmd_status == pci_pkg::STAT_OK) begin
            if (!type_ok) begin
                cmd_status = pci_pkg::STAT_BAD_TYPE;
            end else if (!(ax_set || ax_store || ax_restore || g_set || g_store
                           || g_restore || accu_ld)) begin
                cmd_status = pci_pkg::STAT_BAD_BANK;
            end
        end
        if (!sum_ok) begin
            cmd_status = pci_pkg::STAT_BAD_SUM;
        end
        if (cmd_status != pci_pkg::STAT_OK) begin
            cmd_value  = pci_pkg::VALUE_DONT;
            ax_set     = 1'b0;
            ax_store   = 1'b0;
            ax_restore = 1'b0;
            g_set      = 1'b0;
            g_store    = 1'b0;
            g_restore  = 1'b0;
            accu_ld    = 1'b0;
        end
    end

    // sequencer; frames for other addresses are dropped without reply
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pci_pkg::PCI_LOAD;
        end else begin
            unique case (state_q)
                pci_pkg::PCI_LOAD:  if (load_last) state_q <= pci_pkg::PCI_IDLE;
                pci_pkg::PCI_IDLE:  if (go && addr_hit) state_q <= pci_pkg::PCI_REPLY;
                pci_pkg::PCI_REPLY: if (reply_ready_in) state_q <= pci_pkg::PCI_IDLE;
                default:            state_q <= pci_pkg::PCI_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ld_idx_q <= '0;
        end else if (state_q == pci_pkg::PCI_LOAD) begin
            ld_idx_q <= ld_idx_q + 1'b1;
        end
    end

    // axis tables; nonvolatile copies carry no reset on purpose
    always_ff @(posedge clk_in) begin
        if (state_q == pci_pkg::PCI_LOAD) begin
            axis_work_q[ld_idx_q] <= axis_nv_q[ld_idx_q];
        end else if (exec && ax_set) begin
            axis_work_q[idx] <= frm.value;
        end else if (exec && ax_restore) begin
            axis_work_q[idx] <= axis_nv_q[idx];
        end
        if (exec && ax_store) begin
            axis_nv_q[idx] <= axis_work_q[idx];
        end
    end

    // global banks
    always_ff @(posedge clk_in) begin
        if (state_q == pci_pkg::PCI_LOAD) begin
            g0_work_q[ld_idx_q] <= g0_nv_q[ld_idx_q];
            if (auto_restore_q) begin
                g2_work_q[ld_idx_q] <= g2_nv_q[ld_idx_q];
            end
        end else if (exec && g_set) begin
            unique case (frm.bank)
                pci_pkg::BANK_MODULE: begin
                    g0_work_q[idx] <= frm.value;
                    g0_nv_q[idx]   <= frm.value;
                end
                pci_pkg::BANK_USER:   g2_work_q[idx] <= frm.value;
                default:              g3_work_q[idx] <= frm.value;
            endcase
        end else if (exec && g_store) begin
            if (frm.bank == pci_pkg::BANK_USER) begin
                g2_nv_q[idx] <= g2_work_q[idx];
            end else begin
                g0_nv_q[idx] <= g0_work_q[idx];
            end
        end else if (exec && g_restore) begin
            if (frm.bank == pci_pkg::BANK_USER) begin
                g2_work_q[idx] <= g2_nv_q[idx];
            end else begin
                g0_work_q[idx] <= g0_nv_q[idx];
            end
        end
    end

    // accumulator only follows reads in standalone operation
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            accu_q <= pci_pkg::ACCU_RESET;
        end else if (exec && accu_ld && standalone_q) begin
            accu_q <= cmd_value;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reply_q   <= '0;
            cmd_idx_q <= '0;
        end else if (go && addr_hit) begin
            reply_q.module_addr <= MODULE_ADDR;
            reply_q.status      <= cmd_status;
            reply_q.opcode      <= frm.opcode;
            reply_q.value       <= cmd_value;
            cmd_idx_q           <= idx;
        end
    end

    assign reply_valid_out = (state_q == pci_pkg::PCI_REPLY);
    assign reply_out       = reply_q;
    assign accu_out        = accu_q;
    assign busy_out        = (state_q == pci_pkg::PCI_LOAD);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_cmd(logic [7:0] op);
        exec && (frm.opcode == op) && (cmd_status == pci_pkg::STAT_OK);
    endsequence

    AST_GET_AXIS_ACCU: assert property (s_cmd(pci_pkg::OP_GET_AXIS) ##0 standalone_q
        |=> accu_q == axis_work_q[cmd_idx_q])
        else $error("axis read did not reach accumulator");
    AST_READ_REPLY: assert property (s_cmd(pci_pkg::OP_GET_AXIS)
        |=> reply_valid_out && reply_q.status == pci_pkg::STAT_OK
            && reply_q.value == axis_work_q[cmd_idx_q])
        else $error("axis read reply wrong");
    AST_STORE_AXIS: assert property (s_cmd(pci_pkg::OP_STORE_AXIS)
        |=> axis_nv_q[cmd_idx_q] == axis_work_q[cmd_idx_q] && reply_q.status == 8'h64)
        else $error("axis store failed");
    AST_RESTORE_AXIS: assert property (s_cmd(pci_pkg::OP_RESTORE_AXIS)
        |=> axis_work_q[cmd_idx_q] == axis_nv_q[cmd_idx_q])
        else $error("axis restore failed");
    AST_POWER_LOAD: assert property ($past(busy_out) && !busy_out
        |-> ld_idx_q == '0 && $past(ld_idx_q) == IDX_W'(NUM_PARAMS - 1))
        else $error("power-up load incomplete");
    AST_SET_MODULE: assert property (s_cmd(pci_pkg::OP_SET_GLOBAL)
        ##0 frm.bank == pci_pkg::BANK_MODULE
        |=> g0_nv_q[cmd_idx_q] == g0_work_q[cmd_idx_q])
        else $error("module setting not committed");
    AST_BAD_BANK: assert property (exec && frm.opcode == pci_pkg::OP_SET_GLOBAL
        && type_ok && frm.bank == 8'h01 |=> reply_q.status == pci_pkg::STAT_BAD_BANK)
        else $error("bank 1 accepted");
    AST_DIRECT_ACCU: assert property (s_cmd(pci_pkg::OP_GET_GLOBAL) ##0 !standalone_q
        |=> $stable(accu_q))
        else $error("direct read changed accumulator");
    AST_STORE_USER: assert property (s_cmd(pci_pkg::OP_STORE_GLOBAL)
        ##0 frm.bank == pci_pkg::BANK_USER |=> g2_nv_q[cmd_idx_q] == g2_work_q[cmd_idx_q])
        else $error("user variable store failed");
    AST_RESTORE_USER: assert property (s_cmd(pci_pkg::OP_RESTORE_GLOBAL)
        ##0 frm.bank == pci_pkg::BANK_USER |=> g2_work_q[cmd_idx_q] == g2_nv_q[cmd_idx_q])
        else $error("user variable restore failed");
    AST_BAD_SUM: assert property (go && addr_hit && !sum_ok
        |=> reply_valid_out && reply_q.status == pci_pkg::STAT_BAD_SUM [*1] ##1 1'b1)
        else $error("bad checksum not rejected");
    AST_REPLY_HOLD: assert property (reply_valid_out && !reply_ready_in
        |=> reply_valid_out && $stable(reply_q))
        else $error("reply dropped before accepted");
endmodule // pci_core
`default_nettype wire

/* File: test/pci_host_model.sv */
// host-side model that sends command frames and collects replies
`default_nettype none
module pci_host_model (
    // clock
    input  wire logic                clk_in,
    // byte stream to the device
    output logic                     byte_valid_out,
    output logic [7:0]               byte_out,
    input  wire logic                byte_ready_in,
    // reply from the device
    input  wire logic                reply_valid_in,
    output logic                     reply_ready_out,
    input  wire pci_pkg::pci_reply_s reply_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int stalls = 0;

    initial begin
        byte_valid_out  = 1'b0;
        byte_out        = 8'h00;
        reply_ready_out = 1'b0;
    end

    // one whole frame, each byte held until the device takes it
    task automatic send(input logic [7:0] addr, op, ptype, bank, input logic [31:0] value,
                        input logic bad_sum);
        logic [7:0] b [9];
        int         w;
        b = '{addr, op, ptype, bank, value[31:24], value[23:16], value[15:8], value[7:0],
              8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        if (bad_sum) b[8] = ~b[8];
        @(posedge clk_in);
        for (int i = 0; i < 9; i++) begin
            byte_valid_out <= 1'b1;
            byte_out       <= b[i];
            w = 0;
            do begin
                @(posedge clk_in);
                w++;
            end while (!byte_ready_in && w < 400);
            if (w >= 400) stalls++;
        end
        byte_valid_out <= 1'b0;
        // released line must not keep showing the last byte
        byte_out       <= ~b[8];
    endtask

    // waits for a reply, stalls a while, then accepts it
    task automatic take(input int stall, output pci_pkg::pci_reply_s r, output logic got);
        int w;
        w   = 0;
        got = 1'b0;
        r   = '0;
        do begin
            @(posedge clk_in);
            w++;
        end while (!reply_valid_in && w < 400);
        if (!reply_valid_in) return;
        repeat (stall) @(posedge clk_in);
        reply_ready_out <= 1'b1;
        @(posedge clk_in);
        r   = reply_in;
        got = reply_valid_in;
        reply_ready_out <= 1'b0;
    endtask
endmodule // pci_host_model
`default_nettype wire

/* File: test/tb_parameter_command_interpreter.sv */
// self-checking bench for the parameter command interpreter core
`default_nettype none
module tb_parameter_command_interpreter;
    timeunit 1ns;
    timeprecision 1ps;

    // short load phase keeps the run brief
    localparam int unsigned NP       = 16;
    localparam logic [7:0]  ADDR     = pci_pkg::ADDR_DEFAULT;
    localparam logic [31:0] AX_SAVED = 32'h1234_5678;
    localparam logic [31:0] AX_WORK  = 32'ha5a5_0f0f;
    localparam logic [31:0] GV       = 32'hc0de_0000;

    logic                clk;
    logic                rst_n = 1'b0;
    logic                standalone = 1'b0;
    logic                auto_restore = 1'b1;
    logic                byte_valid;
    logic [7:0]          byte_data;
    logic                byte_ready;
    logic                reply_valid;
    logic                reply_ready;
    pci_pkg::pci_reply_s reply;
    logic [31:0]         accu;
    logic                busy;
    int                  mismatches = 0;
    int                  checks = 0;
    pci_pkg::pci_reply_s r;
    logic                got;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pci_core #(.NUM_PARAMS(NP), .MODULE_ADDR(ADDR)) i_dut (
        .clk_in(clk), .rst_n_in(rst_n), .standalone_in(standalone),
        .auto_restore_in(auto_restore), .byte_valid_in(byte_valid), .byte_in(byte_data),
        .byte_ready_out(byte_ready), .reply_valid_out(reply_valid),
        .reply_ready_in(reply_ready), .reply_out(reply), .accu_out(accu), .busy_out(busy)
    );

    pci_host_model i_host (
        .clk_in(clk), .byte_valid_out(byte_valid), .byte_out(byte_data),
        .byte_ready_in(byte_ready), .reply_valid_in(reply_valid),
        .reply_ready_out(reply_ready), .reply_in(reply)
    );

    task automatic check(input string what, input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // auto restore only acts in the load phase that follows reset, so each mode gets its own reset
    task automatic restart(input logic sa, ar);
        int w;
        @(posedge clk);
        rst_n        <= 1'b0;
        standalone   <= sa;
        auto_restore <= ar;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (busy !== 1'b0 && w < 200);
        check("load phase length", w, NP + 3);
    endtask

    task automatic expect_reply(input logic [7:0] op, status, input logic [31:0] exp);
        check("reply present", got, 1'b1);
        check("reply address", r.module_addr, ADDR);
        check("reply opcode", r.opcode, op);
        check("reply status", r.status, status);
        check("reply value", r.value, exp);
    endtask

    task automatic cmd(input logic [7:0] op, ptype, bank, input logic [31:0] value,
                       input logic [31:0] exp = pci_pkg::VALUE_DONT,
                       input logic [7:0] status = pci_pkg::STAT_OK, input logic bad = 1'b0);
        i_host.send(ADDR, op, ptype, bank, value, bad);
        i_host.take(op % 3, r, got);
        expect_reply(op, status, exp);
    endtask

    task automatic s_axis();
        cmd(pci_pkg::OP_SET_AXIS, 8'h03, 8'h00, AX_SAVED);
        cmd(pci_pkg::OP_STORE_AXIS, 8'h03, 8'h00, 32'hffff_ffff);
        cmd(pci_pkg::OP_SET_AXIS, 8'h03, 8'h00, AX_WORK);
        cmd(pci_pkg::OP_GET_AXIS, 8'h03, 8'h00, 32'h0, AX_WORK);
        check("accu in host mode", accu, pci_pkg::ACCU_RESET);
        cmd(pci_pkg::OP_RESTORE_AXIS, 8'h03, 8'h00, 32'h0);
        cmd(pci_pkg::OP_GET_AXIS, 8'h03, 8'h00, 32'h0, AX_SAVED);
        cmd(pci_pkg::OP_SET_AXIS, 8'h03, 8'h00, AX_WORK);
    endtask

    task automatic s_global();
        for (int b = 0; b < 4; b++) begin
            if (b == 1)
                cmd(pci_pkg::OP_SET_GLOBAL, 8'h05, 8'h01, 32'h0, 32'h0,
                    pci_pkg::STAT_BAD_BANK);
            else
                cmd(pci_pkg::OP_SET_GLOBAL, 8'h05, 8'(b), GV + b);
        end
        for (int b = 0; b < 4; b++) begin
            if (b != 1)
                cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, 8'(b), 32'h0, GV + b);
        end
        cmd(pci_pkg::OP_STORE_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0);
        cmd(pci_pkg::OP_STORE_GLOBAL, 8'h05, pci_pkg::BANK_IRQ, 32'h0, 32'h0,
            pci_pkg::STAT_BAD_BANK);
        cmd(pci_pkg::OP_SET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0bad_0bad);
        cmd(pci_pkg::OP_RESTORE_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0);
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0, GV + 2);
    endtask

    task automatic s_frame();
        logic seen;
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, 8'h00, 32'h0, 32'h0, pci_pkg::STAT_BAD_SUM,
            1'b1);
        cmd(8'h20, 8'h00, 8'h00, 32'h0, 32'h0, pci_pkg::STAT_BAD_CMD);
        cmd(pci_pkg::OP_GET_AXIS, 8'(NP), 8'h00, 32'h0, 32'h0, pci_pkg::STAT_BAD_TYPE);
        cmd(pci_pkg::OP_GET_AXIS, 8'h03, 8'h01, 32'h0, 32'h0, pci_pkg::STAT_BAD_BANK);
        i_host.send(ADDR + 8'h01, pci_pkg::OP_SET_AXIS, 8'h03, 8'h00, 32'h0, 1'b0);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            if (reply_valid !== 1'b0) seen = 1'b1;
        end
        check("foreign frame silent", seen, 1'b0);
        // second frame queued while the first reply is still pending
        i_host.send(ADDR, pci_pkg::OP_GET_AXIS, 8'h03, 8'h00, 32'h0, 1'b0);
        i_host.send(ADDR, pci_pkg::OP_GET_GLOBAL, 8'h05, 8'h03, 32'h0, 1'b0);
        i_host.take(4, r, got);
        expect_reply(pci_pkg::OP_GET_AXIS, pci_pkg::STAT_OK, AX_WORK);
        i_host.take(0, r, got);
        expect_reply(pci_pkg::OP_GET_GLOBAL, pci_pkg::STAT_OK, GV + 3);
    endtask

    task automatic s_power();
        cmd(pci_pkg::OP_GET_AXIS, 8'h03, 8'h00, 32'h0, AX_SAVED);
        check("accu after axis read", accu, AX_SAVED);
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, 8'h00, 32'h0, GV);
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0, GV + 2);
        check("accu after global read", accu, GV + 2);
    endtask

    // auto restore off: user variables keep their working value until asked
    task automatic s_manual();
        cmd(pci_pkg::OP_SET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0bad_0bad);
        restart(1'b0, 1'b0);
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0, 32'h0bad_0bad);
        check("accu in host mode", accu, pci_pkg::ACCU_RESET);
        cmd(pci_pkg::OP_RESTORE_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0);
        cmd(pci_pkg::OP_GET_GLOBAL, 8'h05, pci_pkg::BANK_USER, 32'h0, GV + 2);
    endtask

    initial begin
        restart(1'b0, 1'b1);
        s_axis();
        s_global();
        s_frame();
        restart(1'b1, 1'b1);
        s_power();
        s_manual();
        check("host stalls", i_host.stalls, 0);
        conclude();
    end

    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule // tb_parameter_command_interpreter
`default_nettype wire
